// ===== rtl/tcwb_pkg.sv
// Purpose: constants for the transceiver control word bank
// Assumes: four 24-bit serial words, 2 address bits and 22 data bits
// Notes: pin-dependent defaults indexed by {high pin, low pin}
package tcwb_pkg;
   localparam int WORD_W = 24;
   localparam int DATA_W = 22;
   localparam int ADDR_HI = 23;
   localparam int ADDR_LO = 22;
   localparam int SYNC_STAGES = 2;
   // latch addresses
   localparam logic [1:0] ADDR_SYNTH_OP = 2'h0;
   localparam logic [1:0] ADDR_RX_TUNE = 2'h1;
   localparam logic [1:0] ADDR_RX_DIV = 2'h2;
   localparam logic [1:0] ADDR_TX_DIV = 2'h3;
   // fixed reset parts of the upper data bits
   localparam int FIX_LO = 10;
   localparam logic [11:0] SYNTH_OP_FIX_RST = 12'h07c;
   localparam logic [11:0] RX_TUNE_FIX_RST = 12'h73a;
   localparam logic [1:0] RX_DIV_FIX_RST = 2'h0;
   localparam logic [4:0] TX_DIV_FIX_RST = 5'h04;
   // field positions, synth operating word
   localparam int POS_IDLE_SEL = 21;
   localparam int POS_INPUT_POL = 20;
   localparam int POS_MOD_TYPE = 19;
   localparam int POS_CP_CUR = 18;
   localparam int POS_LOCK_MODE = 17;
   localparam int POS_AMP_ON = 16;
   localparam int POS_TX_POWER = 14;
   localparam int POS_LNA_GAIN = 12;
   localparam int POS_OP_MODE = 10;
   localparam int DIV10_W = 10;
   // receiver tuning word
   localparam int POS_PEAK_DET = 21;
   localparam int POS_DELAY_AMP = 19;
   localparam int POS_LNA_HYST = 18;
   localparam int POS_AFC = 17;
   // rx divider word
   localparam int POS_LNA_SRC = 21;
   localparam int POS_DET_POL = 20;
   localparam int POS_OSC_CUR = 18;
   localparam int POS_BAND = 17;
   localparam int DIV17_W = 17;
   // tx divider word
   localparam int POS_MOD_SRC = 21;
   localparam int POS_LD_TEST = 19;
   localparam int POS_SEC_TEST = 17;
   // pin-dependent defaults, index = {high pin, low pin}
   localparam logic [3:0] BAND_RST = 4'h5;
   localparam logic [7:0] OSC_CUR_RST = 8'h37;
   localparam logic [9:0] REF_DIV_RST [4] = '{10'h010, 10'h020, 10'h020, 10'h012};
   localparam logic [16:0] RX_FB_RST [4] = '{17'h0077f, 17'h00766, 17'h00fcf, 17'h002fe};
   localparam logic [16:0] TX_FB_RST [4] = '{17'h00797, 17'h00796, 17'h00fff, 17'h00319};
endpackage

// ===== rtl/tcwb_shift.sv
// Purpose: pin synchronisers and 24-bit serial shift register
// Assumes: serial clock far slower than ref_clk
// Notes: edges are found on the second and third sampling stages
`timescale 1ns/1ns
module tcwb_shift
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // raw pins
   input wire logic serial_clk_pin,
   input wire logic serial_data_in,
   input wire logic serial_load_enable,
   // synchronised view
   output logic load_level,
   output logic load_rise,
   output logic [tcwb_pkg::WORD_W-1:0] shift_word
);
   logic [1:0] sclk_sync_r;
   logic [1:0] sdata_sync_r;
   logic [1:0] serial_load_enable_sync_r;
   logic sclk_prev_r;
   logic serial_load_enable_prev_r;
   logic [tcwb_pkg::WORD_W-1:0] shift_r;
   logic [tcwb_pkg::WORD_W-1:0] shift_nxt;

   always_comb
   begin
      shift_nxt = shift_r;
      // msb first, older bits fall off the top
      if (sclk_sync_r[1] && !sclk_prev_r)
      begin
         shift_nxt = {shift_r[tcwb_pkg::WORD_W-2:0], sdata_sync_r[1]};
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sclk_sync_r <= 2'h0;
         sdata_sync_r <= 2'h0;
         serial_load_enable_sync_r <= 2'h0;
         sclk_prev_r <= 1'b0;
         serial_load_enable_prev_r <= 1'b0;
         shift_r <= '0;
      end
      else
      begin
         sclk_sync_r <= {sclk_sync_r[0], serial_clk_pin};
         sdata_sync_r <= {sdata_sync_r[0], serial_data_in};
         serial_load_enable_sync_r <= {serial_load_enable_sync_r[0], serial_load_enable};
         sclk_prev_r <= sclk_sync_r[1];
         serial_load_enable_prev_r <= serial_load_enable_sync_r[1];
         shift_r <= shift_nxt;
      end
   end

   assign load_level = serial_load_enable_sync_r[1];
   assign load_rise = serial_load_enable_sync_r[1] && !serial_load_enable_prev_r;
   assign shift_word = shift_r;
endmodule // tcwb_shift

// ===== rtl/tcwb_bank.sv
// Purpose: four control words of the transceiver, loaded over 3-wire port
// Assumes: pins are asynchronous to ref_clk, sampled twice before use
// Notes: words follow pin defaults until the load pin first changes
//
// Overview of operation
// - four words, selected by two-bit address
// - stand-alone uses defaults picked by select pins
// - programmable mode lets host overwrite words
// - pin defaults frozen at programmable mode entry
// - synth word bits 21..16 control fields
// - power, gain, mode fields; bit 13 one
// - synth word upper reset 000001111100
// - tuning word enables; host writes bit 20 one
// - tuning word upper reset 011100111010
// - divider word source, polarity, current, band, divider
// - tx word source and two test settings
// - tx word upper reset 0, 01, 00
// - shift data msb first on clock rise
// - in programmable mode, load rise copies shift into addressed word
// - only last 24 shifted bits kept
// - first load pin change enters programmable mode
`timescale 1ns/1ns
module tcwb_bank
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // three-wire port and select pins
   input wire logic serial_clk_pin,
   input wire logic serial_data_in,
   input wire logic freq_select_low_pin,
   input wire logic freq_select_high_pin,
   // mode
   output logic standalone_mode,
   output logic programmable_mode,
   // whole words
   output logic [tcwb_pkg::DATA_W-1:0] synth_operating_control,
   output logic [tcwb_pkg::DATA_W-1:0] receiver_tuning_control,
   output logic [tcwb_pkg::DATA_W-1:0] rx_divider_band_control,
   output logic [tcwb_pkg::DATA_W-1:0] tx_divider_test_control,
   // synth operating fields
   output logic idle_whole_pll,
   output logic input_polarity,
   output logic modulation_type_select,
   output logic charge_pump_current,
   output logic lock_observation_mode,
   output logic amplifier_on_condition,
   output logic [1:0] transmit_power_step,
   output logic lna_gain_level,
   output logic [1:0] operating_mode_field,
   output logic [9:0] rx_reference_divider,
   // receiver tuning fields
   output logic peak_detector_enable,
   output logic delayed_amp_activation,
   output logic lna_hysteresis_enable,
   output logic auto_freq_control_enable,
   // rx divider fields
   output logic lna_control_source,
   output logic detector_polarity,
   output logic [1:0] oscillator_current,
   output logic freq_band,
   output logic [16:0] rx_feedback_divider,
   // tx divider fields
   output logic modulation_control_source,
   output logic [1:0] lock_detect_test_setting,
   output logic [1:0] second_test_setting,
   output logic [16:0] tx_feedback_divider
);
   typedef enum logic [1:0]
   {
      TCWB_RESET = 2'b00,
      TCWB_ALONE = 2'b01,
      TCWB_PROG = 2'b10,
      TCWB_SETTLE = 2'b11
   } tcwb_mode_e;

   // last count of the post-reset wait for the pin synchronisers
   localparam logic [1:0] SETTLE_LAST = 2'(tcwb_pkg::SYNC_STAGES - 1);

   logic load_level;
   logic load_rise;
   logic [tcwb_pkg::WORD_W-1:0] shift_word;
   logic [1:0] fsh_sync_r;
   logic [1:0] sel_w;
   tcwb_mode_e mode_r;
   tcwb_mode_e mode_nxt;
   logic strap_r;
   logic strap_nxt;
   logic [1:0] settle_r;
   logic [1:0] settle_nxt;
   logic alone_r;
   logic alone_nxt;
   logic prog_r;
   logic prog_nxt;
   logic [tcwb_pkg::DATA_W-1:0] word_r [4];
   logic [tcwb_pkg::DATA_W-1:0] word_nxt [4];

   // pin-dependent default of one word
   function automatic logic [tcwb_pkg::DATA_W-1:0] default_word(input logic [1:0] addr,
                                                                input logic [1:0] sel);
      logic [tcwb_pkg::DATA_W-1:0] w;
      w = '0;
      unique case (addr)
         tcwb_pkg::ADDR_SYNTH_OP:
         begin
            w = {tcwb_pkg::SYNTH_OP_FIX_RST, tcwb_pkg::REF_DIV_RST[sel]};
         end
         tcwb_pkg::ADDR_RX_TUNE:
         begin
            w = {tcwb_pkg::RX_TUNE_FIX_RST, tcwb_pkg::REF_DIV_RST[sel]};
         end
         tcwb_pkg::ADDR_RX_DIV:
         begin
            w = {tcwb_pkg::RX_DIV_FIX_RST, tcwb_pkg::OSC_CUR_RST[2*sel +: 2],
                 tcwb_pkg::BAND_RST[sel], tcwb_pkg::RX_FB_RST[sel]};
         end
         tcwb_pkg::ADDR_TX_DIV:
         begin
            w = {tcwb_pkg::TX_DIV_FIX_RST, tcwb_pkg::TX_FB_RST[sel]};
         end
      endcase
      return w;
   endfunction

   tcwb_shift u_shift
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .serial_clk_pin(serial_clk_pin),
      .serial_data_in(serial_data_in),
      .serial_load_enable(freq_select_low_pin),
      .load_level(load_level),
      .load_rise(load_rise),
      .shift_word(shift_word)
   );

   // low select bit frozen at the strap, so the entry change never picks defaults
   assign sel_w = {fsh_sync_r[1], (mode_r == TCWB_ALONE) ? strap_r : load_level};

   // mode tracking
   always_comb
   begin
      mode_nxt = mode_r;
      strap_nxt = strap_r;
      settle_nxt = settle_r;
      unique case (mode_r)
         TCWB_RESET:
         begin
            settle_nxt = 2'h0;
            mode_nxt = TCWB_SETTLE;
         end
         TCWB_SETTLE:
         begin
            // synchronisers restart empty after reset
            settle_nxt = settle_r + 2'h1;
            if (settle_r == SETTLE_LAST)
            begin
               // strap taken once the sync chain has settled
               strap_nxt = load_level;
               mode_nxt = TCWB_ALONE;
            end
         end
         TCWB_ALONE:
         begin
            if (load_level != strap_r)
            begin
               mode_nxt = TCWB_PROG;
            end
         end
         TCWB_PROG:
         begin
            mode_nxt = TCWB_PROG;
         end
      endcase
   end

   // mode flags registered so the mode pins come straight from flops
   always_comb
   begin
      alone_nxt = (mode_nxt != TCWB_PROG);
      prog_nxt = (mode_nxt == TCWB_PROG);
   end

   // word updates
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         word_nxt[i] = word_r[i];
         if (mode_r != TCWB_PROG)
         begin
            // defaults follow the pins until the mode change freezes them
            word_nxt[i] = default_word(2'(i), sel_w);
         end
         else if (load_rise &&
                  shift_word[tcwb_pkg::ADDR_HI:tcwb_pkg::ADDR_LO] == 2'(i))
         begin
            // only the addressed word changes
            word_nxt[i] = shift_word[tcwb_pkg::DATA_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fsh_sync_r <= 2'h0;
         mode_r <= TCWB_RESET;
         strap_r <= 1'b0;
         settle_r <= 2'h0;
         alone_r <= 1'b1;
         prog_r <= 1'b0;
         for (int i = 0; i < 4; i++)
         begin
            word_r[i] <= '0;
         end
      end
      else
      begin
         fsh_sync_r <= {fsh_sync_r[0], freq_select_high_pin};
         mode_r <= mode_nxt;
         strap_r <= strap_nxt;
         settle_r <= settle_nxt;
         alone_r <= alone_nxt;
         prog_r <= prog_nxt;
         for (int i = 0; i < 4; i++)
         begin
            word_r[i] <= word_nxt[i];
         end
      end
   end

   assign standalone_mode = alone_r;
   assign programmable_mode = prog_r;
   assign synth_operating_control = word_r[0];
   assign receiver_tuning_control = word_r[1];
   assign rx_divider_band_control = word_r[2];
   assign tx_divider_test_control = word_r[3];

   // synth operating fields
   assign idle_whole_pll = word_r[0][tcwb_pkg::POS_IDLE_SEL];
   assign input_polarity = word_r[0][tcwb_pkg::POS_INPUT_POL];
   assign modulation_type_select = word_r[0][tcwb_pkg::POS_MOD_TYPE];
   assign charge_pump_current = word_r[0][tcwb_pkg::POS_CP_CUR];
   assign lock_observation_mode = word_r[0][tcwb_pkg::POS_LOCK_MODE];
   assign amplifier_on_condition = word_r[0][tcwb_pkg::POS_AMP_ON];
   assign transmit_power_step = word_r[0][tcwb_pkg::POS_TX_POWER +: 2];
   assign lna_gain_level = word_r[0][tcwb_pkg::POS_LNA_GAIN];
   assign operating_mode_field = word_r[0][tcwb_pkg::POS_OP_MODE +: 2];
   assign rx_reference_divider = word_r[0][tcwb_pkg::DIV10_W-1:0];

   // receiver tuning fields
   assign peak_detector_enable = word_r[1][tcwb_pkg::POS_PEAK_DET];
   assign delayed_amp_activation = word_r[1][tcwb_pkg::POS_DELAY_AMP];
   assign lna_hysteresis_enable = word_r[1][tcwb_pkg::POS_LNA_HYST];
   assign auto_freq_control_enable = word_r[1][tcwb_pkg::POS_AFC];

   // rx divider fields
   assign lna_control_source = word_r[2][tcwb_pkg::POS_LNA_SRC];
   assign detector_polarity = word_r[2][tcwb_pkg::POS_DET_POL];
   assign oscillator_current = word_r[2][tcwb_pkg::POS_OSC_CUR +: 2];
   assign freq_band = word_r[2][tcwb_pkg::POS_BAND];
   assign rx_feedback_divider = word_r[2][tcwb_pkg::DIV17_W-1:0];

   // tx divider fields
   assign modulation_control_source = word_r[3][tcwb_pkg::POS_MOD_SRC];
   assign lock_detect_test_setting = word_r[3][tcwb_pkg::POS_LD_TEST +: 2];
   assign second_test_setting = word_r[3][tcwb_pkg::POS_SEC_TEST +: 2];
   assign tx_feedback_divider = word_r[3][tcwb_pkg::DIV17_W-1:0];
endmodule // tcwb_bank

// ===== test/tcwb_bank_props.sv
// Purpose: port assertions for the control word bank
// Assumes: one ref_clk domain, synchronous active-high reset
// Notes: load latency window allows for pin sampling jitter
`timescale 1ns/1ns
module tcwb_bank_props
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // load pin
   input wire logic freq_select_low_pin,
   // mode
   input wire logic standalone_mode,
   input wire logic programmable_mode,
   // words
   input wire logic [21:0] synth_operating_control,
   input wire logic [21:0] receiver_tuning_control,
   input wire logic [21:0] rx_divider_band_control,
   input wire logic [21:0] tx_divider_test_control,
   // fields
   input wire logic [1:0] transmit_power_step,
   input wire logic [9:0] rx_reference_divider,
   input wire logic delayed_amp_activation,
   input wire logic [16:0] rx_feedback_divider,
   input wire logic [1:0] lock_detect_test_setting
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [3:0] age_r, age_nxt, rise_r, rise_nxt;
   logic pin_r, pin_nxt;
   always_comb
   begin
      pin_nxt = freq_select_low_pin;
      age_nxt = (age_r == 4'h3) ? age_r : age_r + 4'h1;
      if (rst) age_nxt = 4'h0;
      rise_nxt = (rise_r == 4'hf) ? rise_r : rise_r + 4'h1;
      if (freq_select_low_pin && !pin_r) rise_nxt = 4'h0;
      if (rst) rise_nxt = 4'hf;
   end
   always_ff @(posedge ref_clk)
   begin
      pin_r <= pin_nxt;
      age_r <= age_nxt;
      rise_r <= rise_nxt;
   end
   sequence s_prog_steady;
      programmable_mode && $past(programmable_mode);
   endsequence
   sequence s_strap_change;
      standalone_mode && age_r == 4'h3 && $changed(freq_select_low_pin);
   endsequence
   AST_RST_CLEAR: assert property (
      $fell(rst) |-> $past(synth_operating_control) == 22'h0 && $past(standalone_mode))
      else $error("reset did not clear words and mode");
   AST_MODE_EXCL: assert property (standalone_mode != programmable_mode)
      else $error("both or neither mode flags high");
   AST_PROG_STICKY: assert property (programmable_mode |=> programmable_mode)
      else $error("programmable mode left");
   AST_ENTRY: assert property (s_strap_change |-> ##[1:5] programmable_mode)
      else $error("load pin change did not enter programmable mode");
   AST_SA_UPPER: assert property (
      standalone_mode && age_r == 4'h3 |-> synth_operating_control[21:10] == 12'h07c
      && receiver_tuning_control[21:10] == 12'h73a && rx_divider_band_control[21:20] == 2'h0
      && tx_divider_test_control[21:17] == 5'h04)
      else $error("fixed default bits wrong in stand-alone");
   AST_ONE_WORD: assert property (s_prog_steady |-> $onehot0({
      $changed(synth_operating_control), $changed(receiver_tuning_control),
      $changed(rx_divider_band_control), $changed(tx_divider_test_control)}))
      else $error("more than one word changed at once");
   AST_LOAD_LAT: assert property (s_prog_steady ##0 !$stable({
      synth_operating_control, receiver_tuning_control, rx_divider_band_control,
      tx_divider_test_control}) |-> rise_r inside {[4'h1:4'h6]})
      else $error("word changed without a recent load rise");
   AST_FIELD_A: assert property (
      transmit_power_step == synth_operating_control[15:14]
      && rx_reference_divider == synth_operating_control[9:0])
      else $error("synth word fields differ from word");
   AST_FIELD_B: assert property (delayed_amp_activation == receiver_tuning_control[19])
      else $error("tuning word field differs from word");
   AST_FIELD_C: assert property (rx_feedback_divider == rx_divider_band_control[16:0])
      else $error("divider field differs from word");
   AST_FIELD_D: assert property (
      lock_detect_test_setting == tx_divider_test_control[20:19])
      else $error("test setting differs from word");
endmodule // tcwb_bank_props
bind tcwb_bank tcwb_bank_props i_props (.*);

// ===== test/tcwb_host.sv
// Purpose: host model driving the three-wire port
// Assumes: serial clock 80 ns, low outside frames
// Notes: data line shows inverted last bit when idle
`timescale 1ns/1ns
module tcwb_host
(
   // clock
   input wire logic ref_clk,
   // three-wire pins
   output logic serial_clk_pin,
   output logic serial_data_in,
   output logic serial_load_enable
);
   initial
   begin
      serial_clk_pin = 1'b0;
      serial_data_in = 1'b0;
      serial_load_enable = 1'b0;
   end
   task automatic step();
      repeat (5) @(posedge ref_clk);
      #1;
   endtask
   task automatic set_load(input logic v);
      serial_load_enable = v;
   endtask
   // four junk leading bits, then the word msb first
   task automatic send(input logic [27:0] bits);
      serial_load_enable = 1'b0;
      for (int i = 27; i >= 0; i--)
      begin
         serial_data_in = bits[i];
         step();
         serial_clk_pin = 1'b1;
         step();
         serial_clk_pin = 1'b0;
      end
      serial_data_in = ~serial_data_in;
      step();
      serial_load_enable = 1'b1;
      step();
   endtask
endmodule // tcwb_host

// ===== test/testbench.sv
// Purpose: self-checking bench for the control word bank
// Assumes: host model owns the three serial pins
// Notes: defaults indexed by {high pin, low pin}
`timescale 1ns/1ns
module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic freq_select_high_pin = 1'b0;
   logic serial_clk_pin, serial_data_in, freq_select_low_pin;
   logic standalone_mode, programmable_mode, idle_whole_pll, input_polarity;
   logic [21:0] synth_operating_control, receiver_tuning_control;
   logic [21:0] rx_divider_band_control, tx_divider_test_control;
   logic modulation_type_select, charge_pump_current, lock_observation_mode;
   logic amplifier_on_condition, lna_gain_level, peak_detector_enable;
   logic delayed_amp_activation, lna_hysteresis_enable, auto_freq_control_enable;
   logic lna_control_source, detector_polarity, freq_band, modulation_control_source;
   logic [1:0] transmit_power_step, operating_mode_field, oscillator_current;
   logic [1:0] lock_detect_test_setting, second_test_setting;
   logic [9:0] rx_reference_divider;
   logic [16:0] rx_feedback_divider, tx_feedback_divider;
   int miscompares = 0;
   int tests_run = 0;
   logic [21:0] exp_w [4];
   localparam logic [21:0] pat [4] = '{22'h157555, 22'h3aaaaa, 22'h0f0f0f, 22'h30c30c};
   always #4 ref_clk = ~ref_clk;
   tcwb_bank i_dut (.*);
   tcwb_host i_host (.ref_clk(ref_clk), .serial_clk_pin(serial_clk_pin),
      .serial_data_in(serial_data_in), .serial_load_enable(freq_select_low_pin));
   function automatic logic [21:0] dflt(input logic [1:0] a, input logic [1:0] s);
      logic [9:0] rr;
      logic [16:0] nr, nt;
      logic [2:0] bc;
      case (s)
         2'h0: {rr, nr, nt, bc} = {10'h010, 17'h0077f, 17'h00797, 3'h7};
         2'h1: {rr, nr, nt, bc} = {10'h020, 17'h00766, 17'h00796, 3'h1};
         2'h2: {rr, nr, nt, bc} = {10'h020, 17'h00fcf, 17'h00fff, 3'h7};
         default: {rr, nr, nt, bc} = {10'h012, 17'h002fe, 17'h00319, 3'h0};
      endcase
      case (a)
         2'h0: dflt = {12'h07c, rr};
         2'h1: dflt = {12'h73a, rr};
         2'h2: dflt = {2'h0, bc[1:0], bc[2], nr};
         default: dflt = {5'h04, nt};
      endcase
   endfunction
   task automatic test_done();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_fields();
      cmp(22'({idle_whole_pll, input_polarity, modulation_type_select,
         charge_pump_current, lock_observation_mode, amplifier_on_condition,
         transmit_power_step, lna_gain_level, operating_mode_field, rx_reference_divider}),
         22'({exp_w[0][21:14], exp_w[0][12:0]}));
      cmp(22'({peak_detector_enable, delayed_amp_activation,
         lna_hysteresis_enable, auto_freq_control_enable}),
         22'({exp_w[1][21], exp_w[1][19:17]}));
      cmp(22'({lna_control_source, detector_polarity, oscillator_current,
         freq_band, rx_feedback_divider}), exp_w[2]);
      cmp(22'({modulation_control_source, lock_detect_test_setting,
         second_test_setting, tx_feedback_divider}), exp_w[3]);
   endtask
   task automatic cmp_all();
      cmp_fields();
      cmp(synth_operating_control, exp_w[0]);
      cmp(receiver_tuning_control, exp_w[1]);
      cmp(rx_divider_band_control, exp_w[2]);
      cmp(tx_divider_test_control, exp_w[3]);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic do_reset(input logic [1:0] s);
      tick(1);
      rst = 1'b1;
      freq_select_high_pin = s[1];
      i_host.set_load(s[0]);
      tick(20);
      rst = 1'b0;
      tick(6);
   endtask
   task automatic t_defaults();
      for (int s = 0; s < 4; s++)
      begin
         do_reset(2'(s));
         cmp(22'(standalone_mode), 22'h1);
         for (int a = 0; a < 4; a++) exp_w[a] = dflt(2'(a), 2'(s));
         cmp_all();
         if (s < 2)
         begin
            freq_select_high_pin = 1'b1;
            tick(6);
            for (int a = 0; a < 4; a++) exp_w[a] = dflt(2'(a), 2'(s + 2));
            cmp_all();
         end
      end
   endtask
   // a rising load pin in stand-alone only enters programmable mode
   task automatic t_entry_rise();
      do_reset(2'h0);
      i_host.send({4'h5, 2'h1, pat[1]});
      tick(6);
      cmp(22'(programmable_mode), 22'h1);
      for (int a = 0; a < 4; a++) exp_w[a] = dflt(2'(a), 2'h0);
      cmp_all();
   endtask
   task automatic t_prog();
      do_reset(2'h3);
      i_host.set_load(1'b0);
      tick(6);
      cmp(22'(programmable_mode), 22'h1);
      freq_select_high_pin = 1'b0;
      tick(6);
      for (int a = 0; a < 4; a++) exp_w[a] = dflt(2'(a), 2'h3);
      cmp_all();
      for (int a = 0; a < 4; a++)
      begin
         exp_w[a] = pat[a];
         i_host.send({4'ha, 2'(a), pat[a]});
         tick(4);
         cmp_all();
      end
   endtask
   initial
   begin
      t_defaults();
      t_entry_rise();
      t_prog();
      test_done();
   end
   initial
   begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule // testbench
